/* core/rmp_pkg.sv */
`default_nettype none

package rmp_pkg;

	// ----------------------------------------------------------------
	// Port and pin geometry
	// ----------------------------------------------------------------
	localparam int RMP_PORTS      = 3;
	localparam int RMP_PINS       = 3;
	localparam int RMP_NPINS      = RMP_PORTS * RMP_PINS;
	localparam int RMP_FSEL_W     = 4;
	localparam int RMP_SLOTS      = 8;
	localparam int RMP_SLOT_W     = 3;
	localparam int RMP_CFG_W      = RMP_NPINS * RMP_FSEL_W + 1;
	localparam int RMP_SRC_W      = RMP_PORTS * RMP_SLOTS;

	// ----------------------------------------------------------------
	// Function select field layout and reset value
	// ----------------------------------------------------------------
	localparam int          RMP_FSEL_DIR_BIT = 3;
	localparam int          RMP_EDGE_BIT     = RMP_NPINS * RMP_FSEL_W;
	localparam logic [3:0]  RMP_FSEL_RESET   = 4'h0;
	localparam logic        RMP_EDGE_RESET   = 1'h0;
	localparam logic        RMP_DIR_OUT      = 1'h1;
	localparam logic        RMP_EDGE_FALL    = 1'h1;
	localparam logic [2:0]  RMP_SLOT_NONE    = 3'h0;

	// ----------------------------------------------------------------
	// Crossing depth
	// ----------------------------------------------------------------
	localparam int RMP_SYNC_STAGES = 3;

	typedef enum logic [0:0]
	{
		RMP_CFG_IDLE = 1'b0,
		RMP_CFG_WAIT = 1'b1
	} rmp_cfg_state_t;

endpackage

`default_nettype wire

/* core/rmp_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module rmp_sync3
	import rmp_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock, reset and enable of the receiving domain
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_en,
	// Data from the other domain and its settled copy
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	if (W < 1)
	begin : g_bad_width
		$error("rmp_sync3: width must be at least one");
	end

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// A bit only moves once the second and third stage agree, so a
	// level caught mid-change never reaches the user.
	always_comb
	begin
		next_q = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & o_q);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1  <= '0;
			s2  <= '0;
			s3  <= '0;
			o_q <= '0;
		end
		else if (i_en)
		begin
			s1  <= i_d;
			s2  <= s1;
			s3  <= s2;
			o_q <= next_q;
		end
	end

endmodule

`default_nettype wire

/* core/rmp_pin_mux.sv */
// Contract
// - Each receive pin carries the signal named by its own four-bit select field.
// - Depending on function, a pin drives toward the framer or accepts framer data.
// - After reset every pin is an input with its driver off.
// - Pin direction follows the selected function, no separate direction control.
// - Pin data is sampled and launched on the edge chosen by edge select.
`timescale 1ns/1ps
`default_nettype none

module rmp_pin_mux
	import rmp_pkg::*;
(
	// System clock, reset and clock enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	// Framer receive clock
	input  wire logic        i_framer_rx_clock,
	// Configuration, system domain
	input  wire logic [11:0] i_rx_pin_function_select_line5,
	input  wire logic [11:0] i_rx_pin_function_select_line6,
	input  wire logic [11:0] i_rx_pin_function_select_line7,
	input  wire logic        i_rx_edge_select,
	// Line side signals offered to output functions, system domain
	input  wire logic [7:0]  i_line_src_line5,
	input  wire logic [7:0]  i_line_src_line6,
	input  wire logic [7:0]  i_line_src_line7,
	// Values taken from input functions, system domain
	output logic      [7:0]  o_framer_in_line5,
	output logic      [7:0]  o_framer_in_line6,
	output logic      [7:0]  o_framer_in_line7,
	// Pins of line 5
	input  wire logic        i_rx_multi_pin_a_line5,
	input  wire logic        i_rx_multi_pin_b_line5,
	input  wire logic        i_rx_multi_pin_c_line5,
	output logic             o_rx_multi_pin_a_line5,
	output logic             o_rx_multi_pin_b_line5,
	output logic             o_rx_multi_pin_c_line5,
	output logic             o_rx_multi_pin_a_line5_oe,
	output logic             o_rx_multi_pin_b_line5_oe,
	output logic             o_rx_multi_pin_c_line5_oe,
	// Pins of line 6
	input  wire logic        i_rx_multi_pin_a_line6,
	input  wire logic        i_rx_multi_pin_b_line6,
	input  wire logic        i_rx_multi_pin_c_line6,
	output logic             o_rx_multi_pin_a_line6,
	output logic             o_rx_multi_pin_b_line6,
	output logic             o_rx_multi_pin_c_line6,
	output logic             o_rx_multi_pin_a_line6_oe,
	output logic             o_rx_multi_pin_b_line6_oe,
	output logic             o_rx_multi_pin_c_line6_oe,
	// Pins of line 7
	input  wire logic        i_rx_multi_pin_a_line7,
	input  wire logic        i_rx_multi_pin_b_line7,
	input  wire logic        i_rx_multi_pin_c_line7,
	output logic             o_rx_multi_pin_a_line7,
	output logic             o_rx_multi_pin_b_line7,
	output logic             o_rx_multi_pin_c_line7,
	output logic             o_rx_multi_pin_a_line7_oe,
	output logic             o_rx_multi_pin_b_line7_oe,
	output logic             o_rx_multi_pin_c_line7_oe
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [RMP_CFG_W-1:0]   cfg_in;
	logic [RMP_CFG_W-1:0]   cfg_hold;
	logic [RMP_CFG_W-1:0]   next_cfg_hold;
	logic                   cfg_req;
	logic                   next_cfg_req;
	logic                   cfg_ack_sys;
	rmp_cfg_state_t         cfg_state;
	rmp_cfg_state_t         next_cfg_state;
	logic [RMP_SRC_W-1:0]   in_sys;

	logic                   link_rst_meta;
	logic                   link_rst;
	logic [RMP_SRC_W:0]     fwd_link;
	logic [RMP_SRC_W-1:0]   src_link;
	logic                   en_link;
	logic                   cfg_req_link;
	logic [RMP_CFG_W-1:0]   cfg_link;
	logic [RMP_CFG_W-1:0]   next_cfg_link;
	logic                   cfg_ack;
	logic                   next_cfg_ack;
	logic                   edge_fall;

	logic [RMP_NPINS-1:0]   pin_in;
	logic [RMP_NPINS-1:0]   pin_out;
	logic [RMP_NPINS-1:0]   pin_oe;
	logic [RMP_NPINS-1:0]   next_oe;
	logic [RMP_NPINS-1:0]   next_out;
	logic [RMP_NPINS-1:0]   out_rise;
	logic [RMP_NPINS-1:0]   out_fall;
	logic [RMP_NPINS-1:0]   cap_rise;
	logic [RMP_NPINS-1:0]   cap_fall;
	logic [RMP_NPINS-1:0]   in_val;
	logic [RMP_SRC_W-1:0]   in_link;
	logic [RMP_SRC_W-1:0]   next_in_link;

	assign pin_in = {i_rx_multi_pin_c_line7, i_rx_multi_pin_b_line7, i_rx_multi_pin_a_line7,
	                 i_rx_multi_pin_c_line6, i_rx_multi_pin_b_line6, i_rx_multi_pin_a_line6,
	                 i_rx_multi_pin_c_line5, i_rx_multi_pin_b_line5, i_rx_multi_pin_a_line5};
	assign {o_rx_multi_pin_c_line7, o_rx_multi_pin_b_line7, o_rx_multi_pin_a_line7,
	        o_rx_multi_pin_c_line6, o_rx_multi_pin_b_line6, o_rx_multi_pin_a_line6,
	        o_rx_multi_pin_c_line5, o_rx_multi_pin_b_line5, o_rx_multi_pin_a_line5} = pin_out;
	assign {o_rx_multi_pin_c_line7_oe, o_rx_multi_pin_b_line7_oe, o_rx_multi_pin_a_line7_oe,
	        o_rx_multi_pin_c_line6_oe, o_rx_multi_pin_b_line6_oe, o_rx_multi_pin_a_line6_oe,
	        o_rx_multi_pin_c_line5_oe, o_rx_multi_pin_b_line5_oe,
	        o_rx_multi_pin_a_line5_oe} = pin_oe;
	assign {o_framer_in_line7, o_framer_in_line6, o_framer_in_line5} = in_sys;

	// ----------------------------------------------------------------
	// System side: configuration handshake toward the link
	// ----------------------------------------------------------------
	assign cfg_in = {i_rx_edge_select, i_rx_pin_function_select_line7,
	                 i_rx_pin_function_select_line6, i_rx_pin_function_select_line5};

	// The held copy only changes after the link has acknowledged the
	// previous one, so the link always loads a stable word.
	always_comb
	begin
		next_cfg_state = cfg_state;
		next_cfg_hold  = cfg_hold;
		next_cfg_req   = cfg_req;
		case (cfg_state)
			RMP_CFG_IDLE:
			begin
				if (cfg_in != cfg_hold)
				begin
					next_cfg_hold  = cfg_in;
					next_cfg_req   = ~cfg_req;
					next_cfg_state = RMP_CFG_WAIT;
				end
			end
			RMP_CFG_WAIT:
			begin
				if (cfg_ack_sys == cfg_req)
				begin
					next_cfg_state = RMP_CFG_IDLE;
				end
			end
			default:
			begin
				next_cfg_state = RMP_CFG_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cfg_state <= RMP_CFG_IDLE;
			cfg_hold  <= {RMP_EDGE_RESET, {RMP_NPINS{RMP_FSEL_RESET}}};
			cfg_req   <= 1'b0;
		end
		else if (i_clk_en)
		begin
			cfg_state <= next_cfg_state;
			cfg_hold  <= next_cfg_hold;
			cfg_req   <= next_cfg_req;
		end
	end

	rmp_sync3 #(.W(1)) u_ack_sync
	(
		.i_clk (i_clk_sys),
		.i_rst (i_sys_rst),
		.i_en  (i_clk_en),
		.i_d   (cfg_ack),
		.o_q   (cfg_ack_sys)
	);

	rmp_sync3 #(.W(RMP_SRC_W)) u_in_sync
	(
		.i_clk (i_clk_sys),
		.i_rst (i_sys_rst),
		.i_en  (i_clk_en),
		.i_d   (in_link),
		.o_q   (in_sys)
	);

	// ----------------------------------------------------------------
	// Link side: reset release, crossings and configuration load
	// ----------------------------------------------------------------
	always_ff @(posedge i_framer_rx_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			link_rst_meta <= 1'b1;
			link_rst      <= 1'b1;
		end
		else
		begin
			link_rst_meta <= 1'b0;
			link_rst      <= link_rst_meta;
		end
	end

	rmp_sync3 #(.W(RMP_SRC_W + 2)) u_fwd_sync
	(
		.i_clk (i_framer_rx_clock),
		.i_rst (link_rst),
		.i_en  (1'b1),
		.i_d   ({cfg_req, i_clk_en, i_line_src_line7, i_line_src_line6, i_line_src_line5}),
		.o_q   ({cfg_req_link, fwd_link})
	);
	assign en_link  = fwd_link[RMP_SRC_W];
	assign src_link = fwd_link[RMP_SRC_W-1:0];
	assign edge_fall = (cfg_link[RMP_EDGE_BIT] == RMP_EDGE_FALL);

	always_comb
	begin
		next_cfg_link = cfg_link;
		next_cfg_ack  = cfg_ack;
		if (cfg_req_link != cfg_ack)
		begin
			next_cfg_link = cfg_hold;
			next_cfg_ack  = cfg_req_link;
		end
	end

	// ----------------------------------------------------------------
	// Link side: per pin function decode
	// ----------------------------------------------------------------
	for (genvar g = 0; g < RMP_NPINS; g++)
	begin : g_pin
		logic [RMP_FSEL_W-1:0] fs;
		assign fs = cfg_link[g*RMP_FSEL_W +: RMP_FSEL_W];
		assign next_oe[g]  = (fs[RMP_FSEL_DIR_BIT] == RMP_DIR_OUT);
		assign next_out[g] = src_link[(g / RMP_PINS) * RMP_SLOTS + int'(fs[2:0])];
		assign in_val[g] = edge_fall ? cap_fall[g] : cap_rise[g];
	end

	// Slots are written in pin order, so the last pin wins; this assumes no slot is claimed by two pins.
	always_comb
	begin
		next_in_link = '0;
		for (int k = 0; k < RMP_PORTS; k++)
		begin
			for (int j = 0; j < RMP_PINS; j++)
			begin
				for (int s = 1; s < RMP_SLOTS; s++)
				begin
					if (!next_oe[k*RMP_PINS+j] &&
					    cfg_link[(k*RMP_PINS+j)*RMP_FSEL_W +: RMP_SLOT_W] == RMP_SLOT_W'(s))
					begin
						next_in_link[k*RMP_SLOTS+s] = in_val[k*RMP_PINS+j];
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Link side: registers on both edges of the framer receive clock
	// ----------------------------------------------------------------
	always_ff @(posedge i_framer_rx_clock or posedge link_rst)
	begin
		if (link_rst)
		begin
			cfg_link <= {RMP_EDGE_RESET, {RMP_NPINS{RMP_FSEL_RESET}}};
			cfg_ack  <= 1'b0;
			pin_oe   <= '0;
			out_rise <= '0;
			cap_rise <= '0;
			in_link  <= '0;
		end
		else if (en_link)
		begin
			cfg_link <= next_cfg_link;
			cfg_ack  <= next_cfg_ack;
			pin_oe   <= next_oe;
			out_rise <= next_out;
			cap_rise <= pin_in;
			in_link  <= next_in_link;
		end
	end

	always_ff @(negedge i_framer_rx_clock or posedge link_rst)
	begin
		if (link_rst)
		begin
			out_fall <= '0;
			cap_fall <= '0;
		end
		else if (en_link)
		begin
			out_fall <= next_out;
			cap_fall <= pin_in;
		end
	end

	// The edge choice needs one flop per edge; a clock mux would glitch.
	assign pin_out = edge_fall ? out_fall : out_rise;

endmodule

`default_nettype wire

/* bench/rmp_pin_mux_props.sv */
`timescale 1ns/1ps
`default_nettype none

module rmp_pin_mux_props
	import rmp_pkg::*;
(
	// Clock, reset and enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	// Configuration and line sources
	input  wire logic [11:0] i_rx_pin_function_select_line5,
	input  wire logic [11:0] i_rx_pin_function_select_line7,
	input  wire logic        i_rx_edge_select,
	input  wire logic [7:0]  i_line_src_line5,
	input  wire logic [7:0]  i_line_src_line7,
	// Watched pins and captured values
	input  wire logic        i_rx_multi_pin_a_line5,
	input  wire logic [7:0]  o_framer_in_line5,
	input  wire logic        o_rx_multi_pin_a_line5,
	input  wire logic        o_rx_multi_pin_a_line5_oe,
	input  wire logic        o_rx_multi_pin_c_line7,
	input  wire logic        o_rx_multi_pin_c_line7_oe
);
	logic [41:0] watch;
	logic [41:0] last;
	logic [3:0]  quiet;
	logic [3:0]  next_quiet;
	logic [11:0] s5;
	logic [11:0] s7;
	logic        settled;

	assign s5 = i_rx_pin_function_select_line5;
	assign s7 = i_rx_pin_function_select_line7;
	assign watch = {s5, s7, i_line_src_line5, i_line_src_line7, i_rx_multi_pin_a_line5,
		i_rx_edge_select};

	// The counter register still shows a long quiet spell at the very edge where an input
	// first changes, so the present sample must also match the last one.
	assign settled = i_clk_en && quiet == 4'hf && watch == last;

	// The crossing takes several link cycles, so checks wait for a long quiet spell.
	always_comb
	begin
		next_quiet = quiet;
		if (!i_clk_en || watch != last)
			next_quiet = 4'h0;
		else if (quiet != 4'hf)
			next_quiet = quiet + 4'h1;
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
		if (i_sys_rst)
			quiet <= 4'h0;
		else
			quiet <= next_quiet;

	always_ff @(posedge i_clk_sys)
		last <= watch;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);

	property p_rst_idle;
		$fell(i_sys_rst) |-> !o_rx_multi_pin_a_line5_oe && !o_rx_multi_pin_c_line7_oe
			&& o_framer_in_line5 == 8'h00;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("pin driven after reset");

	property p_dir_in;
		settled && !s5[3] |-> !o_rx_multi_pin_a_line5_oe;
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("input pin driven");

	property p_dir_out;
		settled && s7[11] |-> o_rx_multi_pin_c_line7_oe;
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("output pin not driven");

	property p_out_val;
		settled && s5[3] |-> o_rx_multi_pin_a_line5 == i_line_src_line5[s5[2:0]];
	endproperty
	a_out_val: assert property (p_out_val) else $error("wrong source on pin");

	property p_out_val7;
		settled && s7[11] |-> o_rx_multi_pin_c_line7 == i_line_src_line7[s7[10:8]];
	endproperty
	a_out_val7: assert property (p_out_val7) else $error("wrong source on pin");

	property p_in_val;
		settled && !s5[3] && s5[2:0] != 3'h0
			|-> o_framer_in_line5[s5[2:0]] == i_rx_multi_pin_a_line5;
	endproperty
	a_in_val: assert property (p_in_val) else $error("pin value not captured");

	property p_slot0;
		o_framer_in_line5[0] == 1'b0;
	endproperty
	a_slot0: assert property (p_slot0) else $error("unused slot set");

	c_out: cover property (settled && s5[3]);
	c_in: cover property (settled && !s5[3] && s5[2:0] != 3'h0);
	c_rst: cover property ($fell(i_sys_rst));
endmodule

bind rmp_pin_mux rmp_pin_mux_props rmp_pin_mux_props_inst (.*);

`default_nettype wire

/* bench/rmp_framer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rmp_framer_model
(
	// Framer receive clock and the device's capture edge
	input  wire logic       i_clk,
	input  wire logic       i_edge,
	// Device side of the nine pins
	input  wire logic [8:0] i_oe,
	input  wire logic [8:0] i_dq,
	// Values the framer sends and the pins it drives
	input  wire logic [8:0] i_val,
	input  wire logic [8:0] i_drv,
	output logic      [8:0] o_pin
);
	logic [8:0] q_r;
	logic [8:0] q_f;

	// Launch on the edge opposite the device's capture edge, so data is settled when taken.
	always_ff @(posedge i_clk)
		q_r <= i_val;
	always_ff @(negedge i_clk)
		q_f <= i_val;

	// A pin nobody drives floats to its pull-up level.
	always_comb
		for (int k = 0; k < 9; k++)
			o_pin[k] = i_oe[k] ? i_dq[k] : (i_drv[k] ? (i_edge ? q_r[k] : q_f[k]) : 1'b1);
endmodule

`default_nettype wire

/* bench/rmp_pin_mux_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rmp_pin_mux_bench
	import rmp_pkg::*;
;
	logic        clk = 0;
	logic        lclk = 0;
	logic        rst = 1;
	logic        en = 1;
	logic        esel = 0;
	logic [11:0] s5 = 0, s6 = 0, s7 = 0;
	logic [7:0]  src5 = 0, src6 = 0, src7 = 0, fin5, fin6, fin7;
	logic [8:0]  oe, dq, pin, val = 0, drv = 0;
	int          failures = 0, n_checks = 0, hi = 0, lo = 0;

	always #12.5 clk = ~clk;
	always #6 lclk = ~lclk;

	rmp_pin_mux rmp_pin_mux_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en),
		.i_framer_rx_clock(lclk), .i_rx_edge_select(esel),
		.i_rx_pin_function_select_line5(s5), .i_rx_pin_function_select_line6(s6),
		.i_rx_pin_function_select_line7(s7), .i_line_src_line5(src5),
		.i_line_src_line6(src6), .i_line_src_line7(src7), .o_framer_in_line5(fin5),
		.o_framer_in_line6(fin6), .o_framer_in_line7(fin7),
		.i_rx_multi_pin_a_line5(pin[0]), .i_rx_multi_pin_b_line5(pin[1]),
		.i_rx_multi_pin_c_line5(pin[2]), .i_rx_multi_pin_a_line6(pin[3]),
		.i_rx_multi_pin_b_line6(pin[4]), .i_rx_multi_pin_c_line6(pin[5]),
		.i_rx_multi_pin_a_line7(pin[6]), .i_rx_multi_pin_b_line7(pin[7]),
		.i_rx_multi_pin_c_line7(pin[8]), .o_rx_multi_pin_a_line5(dq[0]),
		.o_rx_multi_pin_b_line5(dq[1]), .o_rx_multi_pin_c_line5(dq[2]),
		.o_rx_multi_pin_a_line6(dq[3]), .o_rx_multi_pin_b_line6(dq[4]),
		.o_rx_multi_pin_c_line6(dq[5]), .o_rx_multi_pin_a_line7(dq[6]),
		.o_rx_multi_pin_b_line7(dq[7]), .o_rx_multi_pin_c_line7(dq[8]),
		.o_rx_multi_pin_a_line5_oe(oe[0]), .o_rx_multi_pin_b_line5_oe(oe[1]),
		.o_rx_multi_pin_c_line5_oe(oe[2]), .o_rx_multi_pin_a_line6_oe(oe[3]),
		.o_rx_multi_pin_b_line6_oe(oe[4]), .o_rx_multi_pin_c_line6_oe(oe[5]),
		.o_rx_multi_pin_a_line7_oe(oe[6]), .o_rx_multi_pin_b_line7_oe(oe[7]),
		.o_rx_multi_pin_c_line7_oe(oe[8]));

	rmp_framer_model rmp_framer_model_inst (.i_clk(lclk), .i_edge(esel), .i_oe(oe),
		.i_dq(dq), .i_val(val), .i_drv(drv), .o_pin(pin));

	// Tells on which framer clock level each launch of pin a, line 5 happened.
	always @(dq[0])
		if (lclk)
			hi++;
		else
			lo++;

	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle();
		repeat (20) @(negedge clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_out();
		for (int k = 0; k < 8; k++)
		begin
			s5 = {8'h00, 1'b1, k[2:0]};
			s6 = {4'h0, 1'b1, k[2:0], 4'h0};
			s7 = {1'b1, k[2:0], 8'h00};
			src5 = 8'h01 << k;
			src6 = ~(8'h01 << k);
			src7 = 8'h01 << k;
			settle();
			chk("out oe", 9'h111, oe);
			chk("out value", 9'h101, dq & 9'h111);
		end
	endtask

	task automatic t_in();
		for (int e = 0; e < 2; e++)
			for (int k = 1; k < 8; k++)
			begin
				esel = e[0];
				s5 = {8'h00, 1'b0, k[2:0]};
				s6 = {4'h0, 1'b0, k[2:0], 4'h0};
				s7 = {1'b0, k[2:0], 8'h00};
				drv = 9'h111;
				val = 9'h011;
				settle();
				chk("in oe", 9'h000, oe);
				chk("in high", 9'h003, {6'h00, fin7[k], fin6[k], fin5[k]});
				val = 9'h100;
				settle();
				chk("in low", 9'h004, {6'h00, fin7[k], fin6[k], fin5[k]});
			end
		drv = 9'h000;
	endtask

	task automatic t_edge();
		s5 = 12'h008;
		s6 = 12'h000;
		s7 = 12'h000;
		src5 = 8'h00;
		for (int e = 0; e < 2; e++)
		begin
			esel = e[0];
			settle();
			hi = 0;
			lo = 0;
			repeat (6)
			begin
				src5[0] = ~src5[0];
				repeat (8) @(negedge clk);
			end
			chk("rise launches", e ? 9'h000 : 9'h006, hi[8:0]);
			chk("fall launches", e ? 9'h006 : 9'h000, lo[8:0]);
		end
	endtask

	task automatic t_en();
		en = 0;
		s5 = {8'h00, RMP_FSEL_RESET};
		settle();
		chk("frozen oe", 9'h001, oe);
		en = 1;
		settle();
		chk("released oe", 9'h000, oe);
		s5 = 12'h008;
		settle();
		rst = 1;
		repeat (2) @(negedge clk);
		chk("reset oe", 9'h000, oe);
		rst = 0;
		s5 = 12'h000;
		settle();
		chk("idle oe", 9'h000, oe);
	endtask

	initial
	begin
		repeat (3) @(negedge clk);
		rst = 0;
		settle();
		chk("reset oe", 9'h000, oe);
		chk("reset capture", 9'h000, {1'b0, fin5 | fin6 | fin7});
		t_out();
		t_in();
		t_edge();
		t_en();
		report_and_stop();
	end
endmodule

`default_nettype wire
